// *** rtl/fdwd_defines.vh ***
// Window geometry, register offsets, field positions and reset values
`ifndef FDWD_DEFINES_VH
`define FDWD_DEFINES_VH

// ----------------------------------------------------------------
// Window geometry
// ----------------------------------------------------------------
`define FDWD_ADDR_W 13
`define FDWD_SEC_HI 12
`define FDWD_SEC_LO 11
`define FDWD_SEC_BOOT_LO 2'h0
`define FDWD_SEC_BOOT_HI 2'h3
`define FDWD_LDR_HALF_BIT 10
`define FDWD_LDR_AW 10

// ----------------------------------------------------------------
// Register offsets within the window
// ----------------------------------------------------------------
`define FDWD_OFS_CHIP_IDENTIFICATION 13'h1000
`define FDWD_OFS_NOP 13'h1002
`define FDWD_OFS_SCRATCH 13'h1004
`define FDWD_OFS_CTRL 13'h1006
`define FDWD_OFS_DEV_SEL 13'h1008
`define FDWD_OFS_CONFIG 13'h100a
`define FDWD_OFS_OUT_CTL 13'h100c
`define FDWD_OFS_INT_CTL 13'h100e
`define FDWD_OFS_TOGGLE 13'h1046
`define FDWD_OFS_CONFIRM 13'h1076

// ----------------------------------------------------------------
// Mode field encodings and control fields
// ----------------------------------------------------------------
`define FDWD_MODE_RESET 2'h0
`define FDWD_MODE_NORMAL 2'h1
`define FDWD_MODE_DPD 2'h2
`define FDWD_MODE_BAD 2'h3
`define FDWD_CTRL_MODE_HI 1
`define FDWD_CTRL_MODE_LO 0
`define FDWD_CTRL_WREN_BIT 2
`define FDWD_CTRL_BDET_BIT 3
`define FDWD_CTRL_RLAT_BIT 4
`define FDWD_CFG_MAXID_HI 5
`define FDWD_CFG_MAXID_LO 4
`define FDWD_CFG_IFCFG_BIT 7

// ----------------------------------------------------------------
// Reset values and writable masks
// ----------------------------------------------------------------
`define FDWD_RST_CTRL 8'h10
`define FDWD_RST_SCRATCH 8'h00
`define FDWD_RST_DEV_SEL 8'h00
`define FDWD_RST_CONFIG 8'h02
`define FDWD_RST_OUT_CTL 8'h01
`define FDWD_RST_INT_CTL 8'h00
`define FDWD_MASK_DEV_SEL 8'h03
`define FDWD_MASK_CONFIG 8'h30
`define FDWD_ONES_OUT_CTL 8'h14
`define FDWD_ZERO_OUT_CTL 8'hc8
`define FDWD_ZERO_CONFIG 8'h4d
`define FDWD_RFU_CONFIG 8'h0c
`define FDWD_ZERO_CTRL 8'he0

`endif

// *** rtl/fdwd_window.v ***
// Host memory window decode and register bank of the flash disk device
`timescale 1ns/1ps
// How it works
// RL1: Decode 8KB window as four 2KB sections numbered from base.
// RL2: Reset mode reads of sections 1 and 2 return zero.
// RL3: Normal mode maps internal registers into sections 1 and 2; here only section 2 decodes them, section 1 reads zero.
// RL4: Single-die parts show the 1KB boot block in sections 0 and 3.
// RL5: All addresses decode as offsets from the window base.
// RL6: Dual-die Reset mode shows first-die loader twice in sections 0, 3.
// RL7: Dual-die: once cascade-ID field written, second copy becomes die two.
// RL8: Dual-die Normal: section 0 both loaders, section 3 first loader twice.
// RL9: Registers at 1000-100E step two, toggle at 1046, confirm at 1076.
// RL10: Reserved-undefined bits read unspecified and ignore writes.
// RL11: Reserved-zero bits read 0; host writes 0.
// RL12: Reserved-one bits read 1; host writes 1.
// RL13: In Reset mode every register read returns zero.
// RL14: Reset values are what Normal mode first shows after Reset.
// RL15: Chip_identification is read-only fixed code; 16MB variant differs.
// RL16: Mode field: 00 Reset, 01 Normal, 10 Deep Power-Down.
// RL17: Control write counts only if next access writes its complement; boot-section reads in between do not cancel it here.
// RL18: Host programs cascade-ID field with highest discovered device ID.
// RL19: Reset mode ignores writes except control and confirmation.
// RL20: Unassigned register offsets read zero and ignore writes.
`include "fdwd_defines.vh"

module fdwd_window #(
  parameter DUAL_DIE = 0,
  parameter SMALL_PART = 0,
  // Identification codes below are arbitrary
  parameter [7:0] ID_CODE_LARGE = 8'h5a,
  parameter [7:0] ID_CODE_SMALL = 8'h5b
) (
  // Clock, reset, enable
  input wire mclk,
  input wire sys_rst,
  input wire clk_en,
  // Host cycle (one-cycle strobes, same clock domain)
  input wire [12:0] host_addr,
  input wire host_rd,
  input wire host_wr,
  input wire [7:0] host_wdata,
  output reg [7:0] host_rdata_ff,
  // Boot block read port
  output wire [9:0] loader_addr,
  output wire loader_die_sel,
  input wire [7:0] loader_rdata,
  // Straps and status
  input wire if_cfg_pin,
  input wire boot_det_evt,
  input wire reset_latch_evt,
  output wire [1:0] mode_out,
  output wire [1:0] dev_select_out,
  output wire [7:0] out_ctl_out,
  output wire [7:0] int_ctl_out
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  reg [7:0] ctrl_ff;
  reg [7:0] scratch_ff;
  reg [7:0] dev_sel_ff;
  reg [7:0] config_ff;
  reg [7:0] out_ctl_ff;
  reg [7:0] int_ctl_ff;
  reg toggle_ff;
  reg maxid_set_ff;
  reg pend_ff;
  reg [7:0] pend_data_ff;
  reg [2:0] ifcfg_sync_ff;
  reg ifcfg_ff;

  // ----------------------------------------------------------------
  // Section decode
  // ----------------------------------------------------------------
  wire [1:0] section;
  wire is_boot;
  wire is_reg;
  wire normal_mode;
  wire reset_mode;
  wire upper_half;

  // RL1: RL5: Section from offset
  assign section = host_addr[`FDWD_SEC_HI:`FDWD_SEC_LO];
  assign is_boot = (section == `FDWD_SEC_BOOT_LO) ||
                   (section == `FDWD_SEC_BOOT_HI);
  assign is_reg = !is_boot;
  assign normal_mode = (ctrl_ff[`FDWD_CTRL_MODE_HI:`FDWD_CTRL_MODE_LO] ==
                        `FDWD_MODE_NORMAL);
  assign reset_mode = (ctrl_ff[`FDWD_CTRL_MODE_HI:`FDWD_CTRL_MODE_LO] ==
                       `FDWD_MODE_RESET);
  assign upper_half = host_addr[`FDWD_LDR_HALF_BIT];

  // ----------------------------------------------------------------
  // Boot block loader selection
  // ----------------------------------------------------------------
  // RL4: RL6: RL7: RL8: Loader die choice
  assign loader_addr = host_addr[`FDWD_LDR_AW-1:0];
  assign loader_die_sel = (DUAL_DIE != 0) && maxid_set_ff && upper_half &&
                          (section == `FDWD_SEC_BOOT_LO);

  // ----------------------------------------------------------------
  // Register write decode
  // ----------------------------------------------------------------
  wire wr_ctrl;
  wire wr_conf;
  wire wr_other;
  wire confirm_ok;
  wire [7:0] new_ctrl;
  wire [1:0] new_mode;
  wire mode_take;

  assign wr_ctrl = host_wr && is_reg && (host_addr == `FDWD_OFS_CTRL);
  assign wr_conf = host_wr && is_reg && (host_addr == `FDWD_OFS_CONFIRM);
  // RL19: Reset mode write filter
  assign wr_other = host_wr && is_reg && normal_mode;
  // RL17: Complement pairing
  assign confirm_ok = pend_ff && wr_conf && (host_wdata == ~pend_data_ff);
  assign new_ctrl = pend_data_ff;
  assign new_mode = new_ctrl[`FDWD_CTRL_MODE_HI:`FDWD_CTRL_MODE_LO];
  // RL16: Legal code with write enable only
  assign mode_take = confirm_ok && new_ctrl[`FDWD_CTRL_WREN_BIT] &&
                     (new_mode != `FDWD_MODE_BAD);

  // ----------------------------------------------------------------
  // Interface strap synchroniser
  // ----------------------------------------------------------------
  always @(posedge mclk) begin
    if (sys_rst) begin
      ifcfg_sync_ff <= 3'h0;
      ifcfg_ff <= 1'b0;
    end else if (clk_en) begin
      ifcfg_sync_ff <= {ifcfg_sync_ff[1:0], if_cfg_pin};
      if (ifcfg_sync_ff[1] == ifcfg_sync_ff[2]) begin
        ifcfg_ff <= ifcfg_sync_ff[2];
      end
    end
  end

  // ----------------------------------------------------------------
  // Control pairing and mode register
  // ----------------------------------------------------------------
  always @(posedge mclk) begin
    if (sys_rst) begin
      pend_ff <= 1'b0;
      pend_data_ff <= 8'h00;
      ctrl_ff <= `FDWD_RST_CTRL;
    end else if (clk_en) begin
      // RL17: Arm, confirm or cancel
      if (wr_ctrl) begin
        pend_ff <= 1'b1;
        pend_data_ff <= host_wdata;
      end else if ((host_rd && !is_boot) || host_wr) begin
        pend_ff <= 1'b0;
      end
      // RL16: Mode update on confirm
      if (mode_take) begin
        ctrl_ff[`FDWD_CTRL_MODE_HI:`FDWD_CTRL_MODE_LO] <= new_mode;
      end
      // Sticky flags: set wins over clear
      if (boot_det_evt) begin
        ctrl_ff[`FDWD_CTRL_BDET_BIT] <= 1'b1;
      end else if (confirm_ok && new_ctrl[`FDWD_CTRL_BDET_BIT]) begin
        ctrl_ff[`FDWD_CTRL_BDET_BIT] <= 1'b0;
      end
      if (reset_latch_evt) begin
        ctrl_ff[`FDWD_CTRL_RLAT_BIT] <= 1'b1;
      end else if (confirm_ok && new_ctrl[`FDWD_CTRL_RLAT_BIT]) begin
        ctrl_ff[`FDWD_CTRL_RLAT_BIT] <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // General registers
  // ----------------------------------------------------------------
  always @(posedge mclk) begin
    if (sys_rst) begin
      scratch_ff <= `FDWD_RST_SCRATCH;
      dev_sel_ff <= `FDWD_RST_DEV_SEL;
      config_ff <= `FDWD_RST_CONFIG;
      out_ctl_ff <= `FDWD_RST_OUT_CTL;
      int_ctl_ff <= `FDWD_RST_INT_CTL;
      maxid_set_ff <= 1'b0;
      toggle_ff <= 1'b0;
    end else if (clk_en) begin
      // RL20: Unlisted offsets fall through
      if (wr_other) begin
        case (host_addr)
          `FDWD_OFS_SCRATCH: begin
            scratch_ff <= host_wdata;
          end
          `FDWD_OFS_DEV_SEL: begin
            dev_sel_ff <= host_wdata & `FDWD_MASK_DEV_SEL;
          end
          // RL7: Cascade field write
          `FDWD_OFS_CONFIG: begin
            config_ff <= (host_wdata & `FDWD_MASK_CONFIG) |
                         (config_ff & ~`FDWD_MASK_CONFIG);
            maxid_set_ff <= 1'b1;
          end
          // RL12: Forced ones kept
          `FDWD_OFS_OUT_CTL: begin
            out_ctl_ff <= (host_wdata | `FDWD_ONES_OUT_CTL) &
                          ~`FDWD_ZERO_OUT_CTL;
          end
          `FDWD_OFS_INT_CTL: begin
            int_ctl_ff <= host_wdata;
          end
          default: begin
          end
        endcase
      end
      if (host_rd && normal_mode && is_reg &&
          (host_addr == `FDWD_OFS_TOGGLE)) begin
        toggle_ff <= ~toggle_ff;
      end
    end
  end

  // ----------------------------------------------------------------
  // Reserved bit shaping on read
  // ----------------------------------------------------------------
  wire [7:0] ctrl_rd;
  wire [7:0] config_rd;
  wire [7:0] out_ctl_rd;
  wire [7:0] toggle_rd;

  // RL11: Upper control bits read zero
  assign ctrl_rd = ctrl_ff & ~`FDWD_ZERO_CTRL;
  // RL10: RL11: Reserved config bits read zero
  assign config_rd = (config_ff & ~`FDWD_ZERO_CONFIG & ~`FDWD_RFU_CONFIG) |
                     {ifcfg_ff, 7'h00};
  // RL11: RL12: Forced bits shown on every read
  assign out_ctl_rd = (out_ctl_ff | `FDWD_ONES_OUT_CTL) &
                      ~`FDWD_ZERO_OUT_CTL;
  assign toggle_rd = {5'h00, toggle_ff, 2'h0};

  // ----------------------------------------------------------------
  // Read data path
  // ----------------------------------------------------------------
  reg [7:0] reg_rd;

  always @* begin
    // RL9: Register map
    case (host_addr)
      // RL15: Fixed identification
      `FDWD_OFS_CHIP_IDENTIFICATION: begin
        reg_rd = (SMALL_PART != 0) ? ID_CODE_SMALL : ID_CODE_LARGE;
      end
      `FDWD_OFS_SCRATCH: begin
        reg_rd = scratch_ff;
      end
      `FDWD_OFS_CTRL, `FDWD_OFS_CONFIRM: begin
        reg_rd = ctrl_rd;
      end
      `FDWD_OFS_DEV_SEL: begin
        reg_rd = dev_sel_ff;
      end
      `FDWD_OFS_CONFIG: begin
        reg_rd = config_rd;
      end
      `FDWD_OFS_OUT_CTL: begin
        reg_rd = out_ctl_rd;
      end
      `FDWD_OFS_INT_CTL: begin
        reg_rd = int_ctl_ff;
      end
      `FDWD_OFS_TOGGLE: begin
        reg_rd = toggle_rd;
      end
      // RL20: Unassigned reads zero
      default: begin
        reg_rd = 8'h00;
      end
    endcase
  end

  always @(posedge mclk) begin
    if (sys_rst) begin
      host_rdata_ff <= 8'h00;
    end else if (clk_en && host_rd) begin
      if (is_boot) begin
        host_rdata_ff <= loader_rdata;
      // RL2: RL13: Reset mode reads zero
      end else if (reset_mode || !normal_mode) begin
        host_rdata_ff <= 8'h00;
      // RL3: RL14: Registers in Normal mode
      end else begin
        host_rdata_ff <= reg_rd;
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign mode_out = ctrl_ff[`FDWD_CTRL_MODE_HI:`FDWD_CTRL_MODE_LO];
  assign dev_select_out = dev_sel_ff[1:0];
  assign out_ctl_out = out_ctl_ff;
  assign int_ctl_out = int_ctl_ff;

endmodule // fdwd_window

// *** tb/fdwd_window_chk.sv ***
// Checker for the window decode ports
`timescale 1ns/1ps
module fdwd_window_chk #(
  parameter DUAL_DIE = 0,
  parameter SMALL_PART = 0,
  parameter [7:0] ID_CODE_LARGE = 8'h5a,
  parameter [7:0] ID_CODE_SMALL = 8'h5b
) (
  // Clock, reset, enable
  input wire mclk,
  input wire sys_rst,
  input wire clk_en,
  // Host cycle
  input wire [12:0] host_addr,
  input wire host_rd,
  input wire host_wr,
  input wire [7:0] host_wdata,
  input wire [7:0] host_rdata_ff,
  // Boot port and status
  input wire [9:0] loader_addr,
  input wire loader_die_sel,
  input wire [7:0] loader_rdata,
  input wire if_cfg_pin,
  input wire boot_det_evt,
  input wire reset_latch_evt,
  input wire [1:0] mode_out,
  input wire [1:0] dev_select_out,
  input wire [7:0] out_ctl_out,
  input wire [7:0] int_ctl_out
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  wire rd_ok = clk_en && host_rd;
  wire [1:0] sec = host_addr[12:11];
  property p_ofs; loader_addr == host_addr[9:0]; endproperty
  a_ofs: assert property (p_ofs) else $error("boot address wrong");
  property p_rst;
    disable iff (1'b0) sys_rst && clk_en |=> mode_out == 2'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("mode not reset");
  property p_boot;
    rd_ok && (sec == 2'h0 || sec == 2'h3)
      |=> host_rdata_ff == $past(loader_rdata);
  endproperty
  a_boot: assert property (p_boot) else $error("boot read wrong");
  property p_zero;
    rd_ok && mode_out == 2'h0 && (sec == 2'h1 || sec == 2'h2)
      |=> host_rdata_ff == 8'h00;
  endproperty
  a_zero: assert property (p_zero) else $error("nonzero read");
  property p_mode; mode_out != 2'h3; endproperty
  a_mode: assert property (p_mode) else $error("illegal mode");
  property p_chg;
    mode_out != $past(mode_out) && !$past(sys_rst)
      |-> $past(clk_en && host_wr && host_addr == 13'h1076);
  endproperty
  a_chg: assert property (p_chg) else $error("mode changed alone");
  property p_ign;
    clk_en && host_wr && mode_out == 2'h0 && host_addr == 13'h1008
      |=> $stable(dev_select_out);
  endproperty
  a_ign: assert property (p_ign) else $error("write not ignored");
  property p_die; loader_die_sel |-> sec == 2'h0 && host_addr[10]; endproperty
  a_die: assert property (p_die) else $error("die select wrong");
  property p_id;
    rd_ok && mode_out == 2'h1 && host_addr == 13'h1000
      |=> host_rdata_ff ==
          ((SMALL_PART != 0) ? ID_CODE_SMALL : ID_CODE_LARGE);
  endproperty
  a_id: assert property (p_id) else $error("chip_identification wrong");
endmodule // fdwd_window_chk

bind fdwd_window fdwd_window_chk #(.DUAL_DIE(DUAL_DIE),
  .SMALL_PART(SMALL_PART), .ID_CODE_SMALL(ID_CODE_SMALL),
  .ID_CODE_LARGE(ID_CODE_LARGE)) u_chk (.mclk(mclk), .sys_rst(sys_rst),
  .clk_en(clk_en), .host_addr(host_addr), .host_rd(host_rd),
  .host_wr(host_wr), .host_wdata(host_wdata), .host_rdata_ff(host_rdata_ff),
  .loader_addr(loader_addr), .loader_die_sel(loader_die_sel),
  .loader_rdata(loader_rdata), .if_cfg_pin(if_cfg_pin),
  .boot_det_evt(boot_det_evt), .reset_latch_evt(reset_latch_evt),
  .mode_out(mode_out), .dev_select_out(dev_select_out),
  .out_ctl_out(out_ctl_out), .int_ctl_out(int_ctl_out));

// *** tb/fdwd_boot_mem.sv ***
// Boot block memory model holding both die loaders
`timescale 1ns/1ps
module fdwd_boot_mem (
  // Boot read port
  input wire [9:0] loader_addr,
  input wire loader_die_sel,
  output wire [7:0] loader_rdata
);
  assign loader_rdata = loader_addr[7:0]
    ^ {loader_die_sel, loader_addr[9:8], 5'h00};
endmodule // fdwd_boot_mem

// *** tb/fdwd_window_test.sv ***
// Testbench for the window decode and register bank
`timescale 1ns/1ps
module fdwd_window_test;
  reg mclk = 1'b0;
  reg sys_rst = 1'b1;
  reg [12:0] host_addr = 13'h0000;
  reg host_rd = 1'b0;
  reg host_wr = 1'b0;
  reg [7:0] host_wdata = 8'h00;
  reg if_cfg = 1'b0;
  reg boot_det = 1'b0;
  wire [7:0] octl, ictl;
  wire [7:0] rdata, ldata;
  wire [9:0] laddr;
  wire dsel;
  wire [1:0] mode, dev;
  integer fail_count = 0;
  integer cmp_count = 0;
  always #20 mclk = ~mclk;
  fdwd_window #(.DUAL_DIE(1)) u_dut (.mclk(mclk), .sys_rst(sys_rst),
    .clk_en(1'b1), .host_addr(host_addr), .host_rd(host_rd),
    .host_wr(host_wr), .host_wdata(host_wdata), .host_rdata_ff(rdata),
    .loader_addr(laddr), .loader_die_sel(dsel), .loader_rdata(ldata),
    .if_cfg_pin(if_cfg), .boot_det_evt(boot_det), .reset_latch_evt(1'b0),
    .mode_out(mode), .dev_select_out(dev), .out_ctl_out(octl),
    .int_ctl_out(ictl));
  fdwd_boot_mem u_mem (.loader_addr(laddr), .loader_die_sel(dsel),
    .loader_rdata(ldata));
  task check(input [7:0] got, input [7:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [12:0] a, input [7:0] d);
    begin
      @(negedge mclk);
      host_addr = a;
      host_wdata = d;
      host_wr = 1'b1;
      @(negedge mclk);
      host_wr = 1'b0;
    end
  endtask
  task rd(input [12:0] a, input [7:0] exp);
    begin
      @(negedge mclk);
      host_addr = a;
      host_rd = 1'b1;
      @(negedge mclk);
      host_rd = 1'b0;
      check(rdata, exp);
    end
  endtask
  function [7:0] boot(input [9:0] a, input die);
    boot = a[7:0] ^ {die, a[9:8], 5'h00};
  endfunction
  task give_verdict;
    begin
      if (fail_count == 0 && cmp_count > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  initial begin
    #(40 * 4000);
    fail_count = fail_count + 1;
    give_verdict;
  end
  initial begin
    repeat (8) @(negedge mclk);
    sys_rst = 1'b0;
    if_cfg = 1'b1;
    rd(13'h1000, 8'h00);
    rd(13'h0abc, 8'h00);
    rd(13'h17fe, 8'h00);
    rd(13'h0405, boot(10'h005, 1'b0));
    rd(13'h1f05, boot(10'h305, 1'b0));
    wr(13'h1004, 8'h77);
    wr(13'h1008, 8'h01);
    wr(13'h1006, 8'h05);
    wr(13'h1076, 8'hfa);
    rd(13'h1004, 8'h00);
    check({6'h00, mode}, 8'h01);
    rd(13'h1000, 8'h5a);
    rd(13'h1008, 8'h00);
    rd(13'h100e, 8'h00);
    wr(13'h1004, 8'ha5);
    rd(13'h1004, 8'ha5);
    wr(13'h1008, 8'h02);
    rd(13'h1008, 8'h02);
    wr(13'h1010, 8'hff);
    rd(13'h1010, 8'h00);
    wr(13'h100a, 8'h10);
    rd(13'h0405, boot(10'h005, 1'b1));
    rd(13'h0005, boot(10'h005, 1'b0));
    rd(13'h1c05, boot(10'h005, 1'b0));
    rd(13'h100a, 8'h92);
    rd(13'h100c, 8'h15);
    wr(13'h100c, 8'h35);
    rd(13'h100c, 8'h35);
    check(octl, 8'h35);
    wr(13'h100e, 8'h5c);
    check(ictl, 8'h5c);
    rd(13'h100e, 8'h5c);
    @(negedge mclk);
    boot_det = 1'b1;
    @(negedge mclk);
    boot_det = 1'b0;
    rd(13'h1006, 8'h19);
    wr(13'h1006, 8'h18);
    wr(13'h1076, 8'he7);
    rd(13'h1076, 8'h01);
    wr(13'h1006, 8'h04);
    rd(13'h1004, 8'ha5);
    wr(13'h1076, 8'hfb);
    check({6'h00, mode}, 8'h01);
    wr(13'h1006, 8'h04);
    rd(13'h0005, boot(10'h005, 1'b0));
    wr(13'h1076, 8'hfb);
    rd(13'h1004, 8'h00);
    wr(13'h1008, 8'h01);
    check({6'h00, dev}, 8'h02);
    give_verdict;
  end
endmodule // fdwd_window_test
